//--- rtl/aopc_ctrl.sv
// Purpose: offset loop, power modes, output format and tuning registers
// Assumes: one sample per clk; raw sample and overrange come from the core
// Notes: offset scaling uses a shift by the time-constant code
// Contract
// - loop estimates and cancels dc offset up to ten millivolts
// - when enabled with the fast path off, estimate updates and is subtracted every sample
// - 4-bit code n selects 2^n mega-cycles; 1100-1111 reserved
// - hold bit freezes estimate, last value still applied
// - after reset correction off and fast path active
// - full sleep powers all down, outputs hi-z, 100 us wake
// - core sleep powers converter only, 5 us wake
// - buffer-off bit or enable pin tristate outputs, 100 ns wake
// - clock below 1 MSPS forces low-power state
// - twos complement or offset binary from register or pin
// - overdrive gives full scale of matching polarity
// - four-level pin selects format and interface
// - output buffers off while buffer-enable pin low
// - reset pin high makes serial data pin a standby control
// - tuning registers writable only over serial interface
// - each 12-bit sample leaves with a synchronous output clock
// - fast path: raw result after 10 cycles, offset correction bypassed, overdrive still forced
// - serial word: 16 bits on falling edges, address then data
`timescale 1ns/100ps
module aopc_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic resetPin,
  input wire logic serialSelectPinN,
  input wire logic serialClkPin,
  input wire logic serialInPin,
  input wire logic [1:0] formatIfaceSelectPin,
  input wire logic parallelCfg,
  input wire logic outbufEnablePin,
  input wire logic slowClk,
  input wire aopc_pkg::aopc_smp_s rawSample,
  output logic [11:0] dataOut,
  output logic dataOe,
  output logic outClk,
  output logic cmosMode,
  output logic convPowered,
  output logic refPowered,
  output logic lowPower,
  output logic dataValid,
  output logic [7:0] perfTuneGeneral,
  output logic [7:0] perfTuneHighFreq
);
  import aopc_pkg::*;
  logic [2:0] s1_r, s2_r;
  logic [2:0] p1_r, p2_r;
  logic [1:0] lv1_r, lv2_r;
  logic rstPinD_r;
  aopc_wr_s wr;
  logic fmtOb_r, fmtCmos_r, fastOff_r, fullSleep_r, coreSleep_r, bufOff_r;
  logic offsEn_r, offsHold_r;
  logic [3:0] tc_r;
  logic [7:0] perfGen_r, perfHf_r;
  logic signed [47:0] acc_r;
  logic [11:0] pipe_r [SLOW_LAT];
  logic [11:0] out_r;
  logic oe_r, ck_r, cmos_r, conv_r, ref_r, lp_r, val_r;
  aopc_pw_e pw_r;
  logic [16:0] wake_r;
  logic [6:0] bufWake_r;
  logic wasFull_r;
  // pins cross in from outside the clock domain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= 3'h0; s2_r <= 3'h0; p1_r <= 3'h0; p2_r <= 3'h0;
      lv1_r <= 2'h0; lv2_r <= 2'h0;
    end else begin
      s1_r <= {serialSelectPinN, serialClkPin, serialInPin};
      s2_r <= s1_r;
      p1_r <= {resetPin, outbufEnablePin, slowClk};
      p2_r <= p1_r;
      lv1_r <= formatIfaceSelectPin;
      lv2_r <= lv1_r;
    end
  end
  wire pinReset = p2_r[2];
  wire bufPin = p2_r[1];
  wire slowDet = p2_r[0];
  // serial pins only mean a bus while reset pin is low
  wire serialMode = ~pinReset;
  aopc_serial_rx u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .selN(s2_r[2] | ~serialMode),
    .sclk(s2_r[1]),
    .sdin(s2_r[0]),
    .wr(wr)
  );
  wire hwReset = pinReset & ~rstPinD_r;
  wire wrEn = wr.valid & serialMode;
  wire swReset = wrEn && wr.addr == ADDR_RESET && wr.data[BIT_SWRESET];
  wire regReset = !rst_n || hwReset || swReset;
  wire pinStandby = pinReset & s2_r[0];
  always_ff @(posedge clk) begin
    if (!rst_n) rstPinD_r <= 1'b0;
    else rstPinD_r <= pinReset;
  end
  // register file; reset pin pulse and soft reset both restore defaults
  always_ff @(posedge clk) begin
    if (regReset) begin
      fmtOb_r <= 1'b0; fmtCmos_r <= 1'b0; fastOff_r <= 1'b0;
      fullSleep_r <= 1'b0; coreSleep_r <= 1'b0; bufOff_r <= 1'b0;
      offsEn_r <= 1'b0; offsHold_r <= 1'b0; tc_r <= 4'h0;
      perfGen_r <= PERF_RST; perfHf_r <= PERF_RST;
    end else if (wrEn) begin
      case (wr.addr)
        ADDR_FORMAT: begin
          fmtOb_r <= wr.data[BIT_FMT_OB];
          fmtCmos_r <= wr.data[BIT_FMT_CMOS];
        end
        ADDR_LATENCY: fastOff_r <= wr.data[BIT_FAST_OFF];
        ADDR_PDN: begin
          fullSleep_r <= wr.data[BIT_FULL_SLEEP];
          coreSleep_r <= wr.data[BIT_CORE_SLEEP];
          bufOff_r <= wr.data[BIT_OUTBUF_OFF];
        end
        ADDR_OFFS: begin
          offsEn_r <= wr.data[BIT_OFFS_EN];
          offsHold_r <= wr.data[BIT_OFFS_HOLD];
          tc_r <= wr.data[TC_LSB +: 4];
        end
        ADDR_PERF_GEN: perfGen_r <= wr.data;
        ADDR_PERF_HF: perfHf_r <= wr.data;
        default: ;
      endcase
    end
  end
  // format source: pin in parallel configuration, register otherwise
  wire pinOb = lv2_r == PIN_5_8 || lv2_r == PIN_FULL;
  wire pinCmos = lv2_r == PIN_3_8 || lv2_r == PIN_5_8;
  wire useOb = parallelCfg ? pinOb : fmtOb_r;
  wire useCmos = parallelCfg ? pinCmos : fmtCmos_r;
  // offset loop in offset-binary domain; reserved codes clamp to slowest
  wire [3:0] tcUse = (tc_r > TC_MAX) ? TC_MAX : tc_r;
  wire [4:0] shAmt = 5'(MIN_MCYC_LOG2 - 12) + {1'b0, tcUse};
  wire loopOn = fastOff_r & offsEn_r;
  wire signed [12:0] rawS = $signed({1'b0, rawSample.data ^ 12'h800});
  // 48-bit sum so a full-scale offset at the slowest code (2^31 cycles) cannot wrap
  wire signed [47:0] est = acc_r >>> (5'd12 + shAmt);
  wire signed [47:0] err = {{35{rawS[12]}}, rawS} - 48'sd2048 - est;
  wire signed [47:0] corr = {{35{rawS[12]}}, rawS} - est;
  wire [11:0] corrSat = corr > 48'sd4095 ? 12'hFFF : corr < 0 ? 12'h000 : corr[11:0];
  always_ff @(posedge clk) begin
    if (regReset || !offsEn_r) acc_r <= 48'sd0;
    else if (loopOn && !offsHold_r) acc_r <= acc_r + err;
  end
  // processed sample: offset removed then overdrive forced to full scale
  wire [11:0] procOb = loopOn ? corrSat : rawS[11:0];
  wire [11:0] procFmt = useOb ? procOb : procOb ^ 12'h800;
  wire [11:0] posFs = useOb ? POS_FS_OB : POS_FS_2C;
  wire [11:0] negFs = useOb ? NEG_FS_OB : NEG_FS_2C;
  wire [11:0] rawFmt = useOb ? rawS[11:0] : rawSample.data;
  wire [11:0] pathIn = rawSample.ovrPos ? posFs : rawSample.ovrNeg ? negFs
                      : (fastOff_r ? procFmt : rawFmt);
  generate
    for (genvar i = 0; i < SLOW_LAT; i++) begin : g_pipe
      always_ff @(posedge clk) begin
        if (!rst_n) pipe_r[i] <= 12'h000;
        else pipe_r[i] <= (i == 0) ? pathIn : pipe_r[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate
  wire [11:0] tapOut = fastOff_r ? pipe_r[SLOW_LAT - 2] : pipe_r[FAST_LAT - 2];
  // power sequencing, wake counters
  wire sleepReq = fullSleep_r | coreSleep_r | pinStandby | slowDet;
  always_ff @(posedge clk) begin
    if (regReset) begin
      pw_r <= PW_RUN;
      wake_r <= 17'h00000;
    end else begin
      case (pw_r)
        PW_RUN: if (sleepReq) pw_r <= PW_SLEEP;
        PW_SLEEP: if (!sleepReq) begin
          pw_r <= PW_WAKE;
          wake_r <= (fullSleep_r | wasFull_r) ? 17'(WAKE_FULL_CYC) : 17'(WAKE_CORE_CYC);
        end
        PW_WAKE: if (sleepReq) pw_r <= PW_SLEEP;
          else if (wake_r <= 17'h00001) pw_r <= PW_RUN;
          else wake_r <= wake_r - 17'h00001;
        default: pw_r <= PW_RUN;
      endcase
    end
  end
  // full-sleep wake time set on entry since the bit is already clear at exit
  always_ff @(posedge clk) begin
    if (regReset) wasFull_r <= 1'b0;
    else if (pw_r == PW_RUN) wasFull_r <= 1'b0;
    else if (fullSleep_r) wasFull_r <= 1'b1;
  end
  wire bufDis = bufOff_r | ~bufPin | fullSleep_r;
  always_ff @(posedge clk) begin
    if (regReset) bufWake_r <= 7'h00;
    else if (bufDis) bufWake_r <= 7'(WAKE_BUF_CYC);
    else if (bufWake_r != 7'h00) bufWake_r <= bufWake_r - 7'h01;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_r <= 12'h000; oe_r <= 1'b0; ck_r <= 1'b0; cmos_r <= 1'b0;
      conv_r <= 1'b0; ref_r <= 1'b0; lp_r <= 1'b0; val_r <= 1'b0;
    end else begin
      out_r <= tapOut;
      oe_r <= ~bufDis && bufWake_r == 7'h00;
      ck_r <= ~ck_r;
      cmos_r <= useCmos;
      conv_r <= ~(fullSleep_r | coreSleep_r | pinStandby | slowDet);
      ref_r <= ~fullSleep_r;
      lp_r <= slowDet;
      val_r <= pw_r == PW_RUN && !wasFull_r && !sleepReq;
    end
  end
  assign dataOut = out_r;
  assign dataOe = oe_r;
  assign outClk = ck_r;
  assign cmosMode = cmos_r;
  assign convPowered = conv_r;
  assign refPowered = ref_r;
  assign lowPower = lp_r;
  assign dataValid = val_r;
  assign perfTuneGeneral = perfGen_r;
  assign perfTuneHighFreq = perfHf_r;
endmodule // aopc_ctrl

//--- rtl/aopc_serial_rx.sv
// Purpose: three-wire serial write receiver, 16-bit address/data words
// Assumes: serial pins already pass two flip-flops in the caller
// Notes: excess bits of a partial word are dropped when select rises
`timescale 1ns/100ps
module aopc_serial_rx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic selN,
  input wire logic sclk,
  input wire logic sdin,
  output aopc_pkg::aopc_wr_s wr
);
  import aopc_pkg::*;
  logic sclkD_r;
  logic [3:0] cnt_r;
  logic [14:0] sh_r;
  aopc_wr_s wr_r;
  wire fallEdge = sclkD_r & ~sclk & ~selN;
  wire wordDone = fallEdge && cnt_r == 4'hF;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclkD_r <= 1'b0;
      cnt_r <= 4'h0;
      sh_r <= 15'h0000;
      wr_r <= '0;
    end else begin
      sclkD_r <= sclk;
      wr_r.valid <= wordDone;
      if (selN) cnt_r <= 4'h0;
      else if (fallEdge) begin
        cnt_r <= cnt_r + 4'h1;
        sh_r <= {sh_r[13:0], sdin};
      end
      if (wordDone) begin
        wr_r.addr <= sh_r[14:7];
        wr_r.data <= {sh_r[6:0], sdin};
      end
    end
  end
  assign wr = wr_r;
endmodule // aopc_serial_rx

//--- shared/aopc_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: 125 MHz sample clock, 8-bit serial address and data
// Notes: register offsets for bits with no printed offset are local picks
package aopc_pkg;
  localparam int AOPC_DW = 12;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] ADDR_PERF_GEN = 8'h03;
  localparam logic [7:0] ADDR_FORMAT = 8'h3D;
  localparam logic [7:0] ADDR_LATENCY = 8'h42;
  localparam logic [7:0] ADDR_PDN = 8'h3F;
  localparam logic [7:0] ADDR_OFFS = 8'hCF;
  localparam logic [7:0] ADDR_PERF_HF = 8'h4A;
  localparam int BIT_SWRESET = 7;
  localparam int BIT_FMT_OB = 0;
  localparam int BIT_FMT_CMOS = 1;
  localparam int BIT_FAST_OFF = 0;
  localparam int BIT_FULL_SLEEP = 0;
  localparam int BIT_CORE_SLEEP = 1;
  localparam int BIT_OUTBUF_OFF = 2;
  localparam int BIT_OFFS_EN = 7;
  localparam int BIT_OFFS_HOLD = 6;
  localparam int TC_LSB = 0;
  localparam logic [3:0] TC_MAX = 4'hB;
  localparam logic [7:0] PERF_RST = 8'h00;
  localparam int FAST_LAT = 10;
  localparam int SLOW_LAT = 16;
  localparam int CLK_MHZ = 125;
  localparam int WAKE_FULL_US = 100;
  localparam int WAKE_CORE_US = 5;
  localparam int WAKE_BUF_NS = 100;
  localparam int WAKE_FULL_CYC = WAKE_FULL_US * CLK_MHZ;
  localparam int WAKE_CORE_CYC = WAKE_CORE_US * CLK_MHZ;
  localparam int WAKE_BUF_CYC = (WAKE_BUF_NS * CLK_MHZ + 999) / 1000;
  localparam int SLOW_CLK_CYC = CLK_MHZ;
  localparam logic [11:0] POS_FS_OB = 12'hFFF;
  localparam logic [11:0] NEG_FS_OB = 12'h000;
  localparam logic [11:0] POS_FS_2C = 12'h7FF;
  localparam logic [11:0] NEG_FS_2C = 12'h800;
  localparam int MIN_MCYC_LOG2 = 20;
  typedef enum logic [1:0] {
    PIN_GND = 2'h0, PIN_3_8 = 2'h1, PIN_5_8 = 2'h3, PIN_FULL = 2'h2
  } aopc_lvl_e;
  typedef enum logic [1:0] {
    PW_RUN = 2'h0, PW_SLEEP = 2'h1, PW_WAKE = 2'h3
  } aopc_pw_e;
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } aopc_wr_s;
  typedef struct packed {
    logic [11:0] data;
    logic ovrPos;
    logic ovrNeg;
  } aopc_smp_s;
endpackage

//--- test/aopc_ctrl_assertions.sv
// Purpose: port-level checks for aopc_ctrl
// Assumes: one clock, synchronous active-low reset
// Notes: runCnt masks the edges right after reset, where outputs are still zero
`timescale 1ns/100ps
module aopc_ctrl_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic resetPin,
  input wire logic [1:0] formatIfaceSelectPin,
  input wire logic parallelCfg,
  input wire logic outbufEnablePin,
  input wire logic slowClk,
  input wire logic dataOe,
  input wire logic outClk,
  input wire logic cmosMode,
  input wire logic convPowered,
  input wire logic refPowered,
  input wire logic lowPower,
  input wire logic dataValid,
  input wire logic [7:0] perfTuneGeneral,
  input wire logic [7:0] perfTuneHighFreq
);
  import aopc_pkg::*;
  logic [3:0] runCnt;
  wire run = runCnt == 4'hF;
  always_ff @(posedge clk) runCnt <= !rst_n ? 4'h0 : (run ? runCnt : runCnt + 4'h1);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  out_clk_a: assert property (run && dataOe && $past(dataOe) |-> outClk != $past(outClk))
    else $error("output clock did not toggle");
  oe_pin_a: assert property ((!outbufEnablePin && run) [*4] |-> !dataOe)
    else $error("buffers on while enable pin low");
  wr_refuse_a: assert property ((resetPin && run) [*6] |-> $stable(perfTuneGeneral)
    && $stable(perfTuneHighFreq)) else $error("tuning changed in pin mode");
  low_power_a: assert property ((slowClk && run) [*6] |-> lowPower)
    else $error("no low power on slow clock");
  sleep_all_a: assert property (run && !refPowered |-> !convPowered && !dataOe)
    else $error("reference off but core or buffers on");
  conv_valid_a: assert property (run && !convPowered |-> !dataValid)
    else $error("valid data while core off");
  wake_hold_a: assert property (run && $rose(convPowered) |-> !dataValid [*8])
    else $error("valid data too soon after wake");
  iface_sel_a: assert property ((parallelCfg && run && $stable(formatIfaceSelectPin)) [*4] |->
    cmosMode == formatIfaceSelectPin[0]) else $error("wrong interface for pin level");
  cover property (run && !refPowered);
  cover property (run && $rose(convPowered));
  cover property (run && slowClk && lowPower);
endmodule // aopc_ctrl_assertions
bind aopc_ctrl aopc_ctrl_assertions u_chk (.clk, .rst_n, .resetPin, .formatIfaceSelectPin,
  .parallelCfg, .outbufEnablePin, .slowClk, .dataOe, .outClk, .cmosMode, .convPowered,
  .refPowered, .lowPower, .dataValid, .perfTuneGeneral, .perfTuneHighFreq);

//--- test/aopc_host_model.sv
// Purpose: external controller driving the three serial pins
// Assumes: sclk phases of 4 clk, above the 3 the receiver needs
// Notes: idle data line shows the inverse of the last bit
`timescale 1ns/100ps
module aopc_host_model (
  input wire logic clk,
  output logic selN,
  output logic sclk,
  output logic sdin
);
  initial begin
    selN = 1'b1;
    sclk = 1'b0;
    sdin = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] w;
    w = {a, d};
    step(1);
    selN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b1;
      sdin = w[i];
      step(4);
      sclk = 1'b0;
      step(4);
    end
    selN = 1'b1;
    sdin = ~w[0];
  endtask
  task automatic pin_standby(input logic v);
    step(1);
    sdin = v;
  endtask
endmodule // aopc_host_model

//--- test/tb_adc_offset_power_mode_ctrl.sv
// Purpose: self-checking bench for aopc_ctrl
// Assumes: host model writes registers over the serial pins
// Notes: offset loop time constants above 2^20 cycles are too long to run here
`timescale 1ns/100ps
module tb_adc_offset_power_mode_ctrl;
  import aopc_pkg::*;
  logic clk, rst_n, resetPin, selN, sclk, sdin, parallelCfg, oePin, slowClk;
  logic [1:0] lvl;
  aopc_smp_s raw;
  logic [11:0] dataOut;
  logic [7:0] perfG, perfH;
  logic dataOe, outClk, cmosMode, convPowered, refPowered, lowPower, dataValid;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h6083;
  aopc_smp_s hist [$];
  aopc_ctrl u_dut (.clk(clk), .rst_n(rst_n), .resetPin(resetPin), .serialSelectPinN(selN),
    .serialClkPin(sclk), .serialInPin(sdin), .formatIfaceSelectPin(lvl),
    .parallelCfg(parallelCfg), .outbufEnablePin(oePin), .slowClk(slowClk), .rawSample(raw),
    .dataOut(dataOut), .dataOe(dataOe), .outClk(outClk), .cmosMode(cmosMode),
    .convPowered(convPowered), .refPowered(refPowered), .lowPower(lowPower),
    .dataValid(dataValid), .perfTuneGeneral(perfG), .perfTuneHighFreq(perfH));
  aopc_host_model u_host (.clk(clk), .selN(selN), .sclk(sclk), .sdin(sdin));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [11:0] expect_out(aopc_smp_s s, logic ob);
    if (s.ovrPos) return ob ? POS_FS_OB : POS_FS_2C;
    if (s.ovrNeg) return ob ? NEG_FS_OB : NEG_FS_2C;
    return ob ? {~s.data[11], s.data[10:0]} : s.data;
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic stream(input logic ob, input int lat);
    logic [31:0] r;
    hist.delete();
    for (int i = 0; i < 40; i++) begin
      tick(1);
      if (i >= lat) chk(dataOut, expect_out(hist[i - lat], ob));
      r = rnd();
      raw.data = r[11:0];
      raw.ovrPos = r[20:17] == 4'h0;
      raw.ovrNeg = r[24:21] == 4'h0 && !raw.ovrPos;
      hist.push_back(raw);
    end
    $display("test stream done");
  endtask
  task automatic wake(input int cyc);
    int n;
    n = 0;
    while (dataValid !== 1'b1) begin
      tick(1);
      n++;
      if (n > 20000) begin
        error_cnt++;
        end_sim();
      end
    end
    chk({11'h0, n >= cyc - 8 && n <= cyc + 8}, 12'h001);
    $display("test wake done");
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    logic [31:0] r;
    rst_n = 1'b0;
    resetPin = 1'b0;
    parallelCfg = 1'b1;
    lvl = PIN_GND;
    oePin = 1'b1;
    slowClk = 1'b0;
    raw = '0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick(2);
    chk({4'h0, perfG}, {4'h0, PERF_RST});
    r = rnd();
    u_host.write(ADDR_PERF_GEN, r[7:0]);
    u_host.write(ADDR_PERF_HF, 8'h01);
    tick(6);
    chk({4'h0, perfG}, {4'h0, r[7:0]});
    chk({4'h0, perfH}, 12'h001);
    u_host.write(ADDR_PERF_GEN, 8'h03);
    chk({4'h0, perfG}, 12'h003);
    u_host.write(ADDR_RESET, 8'h80);
    tick(6);
    chk({4'h0, perfG}, {4'h0, PERF_RST});
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      lvl = k[1:0];
      tick(4);
      chk({11'h0, cmosMode}, {11'h0, lvl[0]});
      stream(lvl[1], FAST_LAT);
    end
    parallelCfg = 1'b0;
    u_host.write(ADDR_FORMAT, 8'h01);
    stream(1'b1, FAST_LAT);
    u_host.write(ADDR_LATENCY, 8'h01);
    stream(1'b1, SLOW_LAT);
    // steady +2047 input: estimate reaches one code after 513 cycles, two after 1025
    raw = '{data: 12'h7FF, ovrPos: 1'b0, ovrNeg: 1'b0};
    u_host.write(ADDR_OFFS, 8'h80);
    tick(400);
    chk(dataOut, 12'hFFF);
    tick(300);
    chk(dataOut, 12'hFFE);
    u_host.write(ADDR_OFFS, 8'hC0);
    tick(600);
    chk(dataOut, 12'hFFE);
    u_host.write(ADDR_OFFS, 8'h80);
    tick(300);
    chk(dataOut, 12'hFFD);
    u_host.write(ADDR_OFFS, 8'h00);
    tick(SLOW_LAT + 4);
    chk(dataOut, 12'hFFF);
    $display("test offset done");
    oePin = 1'b0;
    tick(4);
    chk({11'h0, dataOe}, 12'h000);
    oePin = 1'b1;
    u_host.write(ADDR_PDN, 8'h04);
    tick(6);
    chk({11'h0, dataOe}, 12'h000);
    u_host.write(ADDR_PDN, 8'h00);
    tick(WAKE_BUF_CYC + 6);
    chk({11'h0, dataOe}, 12'h001);
    u_host.write(ADDR_PDN, 8'h02);
    tick(6);
    chk({10'h0, convPowered, refPowered}, 12'h001);
    u_host.write(ADDR_PDN, 8'h00);
    wake(WAKE_CORE_CYC);
    u_host.write(ADDR_PDN, 8'h01);
    tick(6);
    chk({9'h0, convPowered, refPowered, dataOe}, 12'h000);
    u_host.write(ADDR_PDN, 8'h00);
    wake(WAKE_FULL_CYC);
    resetPin = 1'b1;
    tick(6);
    u_host.write(ADDR_PERF_HF, 8'h5A);
    u_host.pin_standby(1'b1);
    tick(8);
    chk({11'h0, convPowered}, 12'h000);
    chk({4'h0, perfH}, {4'h0, PERF_RST});
    u_host.pin_standby(1'b0);
    resetPin = 1'b0;
    slowClk = 1'b1;
    tick(8);
    chk({11'h0, lowPower}, 12'h001);
    slowClk = 1'b0;
    $display("test power done");
    end_sim();
  end
endmodule // tb_adc_offset_power_mode_ctrl
